// ---- rtl/ucl_link.sv ----
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ucl_link
	import ucl_pkg::*;
#(
	parameter int DARK_CYCLES  = LED_DARK_CYCLES,
	parameter int BLINK_CYCLES = LED_BLINK_CYCLES
) (
	input  wire logic                   clock,
	input  wire logic                   rst,
	input  wire logic [ADDR_W-1:0]      regAddr,
	input  wire logic [DATA_W-1:0]      regWrData,
	input  wire logic                   regWrite,
	input  wire logic                   regRead,
	output logic      [DATA_W-1:0]      regRdData,
	input  wire logic                   vbusSense,
	input  wire logic                   portModeSelectHi,
	input  wire logic                   portModeSelectLo,
	input  wire logic                   dmaWidthSelect,
	input  wire logic                   ale,
	input  wire logic                   muxedAddrDataBit0,
	input  wire logic                   rxLine,
	input  wire logic                   rxSampleTick,
	input  wire logic                   sieSuspend,
	input  wire logic                   enumEvent,
	input  wire logic                   addrAssigned,
	input  wire logic                   ackDone,
	output logic                        pullUpAttach,
	output logic                        suspendActive,
	output logic                        cmdSelect,
	output logic                        linkStatusLedN,
	output logic                        programmableClockOut,
	output logic                        rxBitValid,
	output logic                        rxBitData,
	output logic                        rxStuffError,
	output logic                        dmaEnabled,
	output logic      [DMA_EP_W-1:0]    dmaEndpoint,
	output logic      [DMA_BURST_W-1:0] dmaBurstBytes
);

	typedef struct packed {
		ucl_conn_type           conn;
		logic                   connectCmd;
		logic                   clkOutEn;
		logic                   slowEn;
		logic [DIV_W-1:0]       clkDiv;
		logic [DMA_EP_W-1:0]    dmaEp;
		logic                   dmaEn;
		logic [DMA_BURST_W-1:0] dmaBurst;
		logic [ALLOC_W-1:0]     allocSize;
		logic                   allocDouble;
		ucl_led_type            led;
		logic [LED_CNT_W-1:0]   ledCnt;
		logic                   ledLit;
		logic                   aleQ;
		logic                   cmdSel;
		ucl_mode_type           mode;
		logic                   dmaWide;
		logic                   strapDone;
		logic                   suspend;
		logic [DATA_W-1:0]      rdData;
	} ucl_link_type;

	localparam logic [LED_CNT_W-1:0] DARK_LOAD  = LED_CNT_W'(DARK_CYCLES - 1);
	localparam logic [LED_CNT_W-1:0] BLINK_LOAD = LED_CNT_W'(BLINK_CYCLES - 1);

	ucl_link_type           state;
	ucl_link_type           next_state;
	logic                   suspendNow;
	logic                   modeReserved;
	logic                   dmaWidthOk;
	logic [ALLOC_W:0]       allocPhysical;
	logic                   allocOverflow;
	logic [DATA_W-1:0]      statusWord;
	logic [DATA_W-1:0]      readWord;
	logic [DIV_W-1:0]       halfPeriod;
	logic                   clkOutRun;
	logic [DMA_EP_W-1:0]    wrEp;
	logic [DMA_BURST_W-1:0] wrBurst;

	// Without bus power the link is held in suspend regardless of the lines
	assign suspendNow = sieSuspend || !vbusSense;

	// Mode decode and DMA width check against the strapped port mode
	assign modeReserved = (state.mode == MODE_RSV1) || (state.mode == MODE_RSV3);
	assign dmaWidthOk   = ((state.mode == MODE_16) && state.dmaWide)
	                   || ((state.mode == MODE_8) && !state.dmaWide);

	// Physical size of the requested allocation against the shared buffer
	assign allocPhysical = state.allocDouble ? {state.allocSize, 1'b0}
	                                         : {1'b0, state.allocSize};
	assign allocOverflow = allocPhysical > BUF_BYTES;

	// Status word
	always_comb begin
		statusWord                                = '0;
		statusWord[ST_VBUS]                       = vbusSense;
		statusWord[ST_PULLUP]                     = state.conn == CONN_ATTACHED;
		statusWord[ST_SUSPEND]                    = state.suspend;
		statusWord[ST_ADDRESS]                    = addrAssigned;
		statusWord[ST_LED]                        = state.ledLit;
		statusWord[ST_CMDSEL]                     = state.cmdSel;
		statusWord[ST_MODE_LSB +: 2]              = state.mode;
		statusWord[ST_MODE_RSV]                   = modeReserved;
		statusWord[ST_DMA_OK]                     = dmaWidthOk;
		statusWord[ST_ALLOC_OV]                   = allocOverflow;
		statusWord[ST_WAIT]                       = state.conn == CONN_WAIT;
	end

	// Read decode; unmapped offsets read zero
	always_comb begin
		readWord = '0;
		case (regAddr)
			REG_CTRL: begin
				readWord[CTRL_CONNECT]   = state.connectCmd;
				readWord[CTRL_PROGRAMMABLE_CLOCK_OUT_EN] = state.clkOutEn;
				readWord[CTRL_SLOW_EN]   = state.slowEn;
			end
			REG_CLKDIV: begin
				readWord[DIV_W-1:0] = state.clkDiv;
			end
			REG_DMACFG: begin
				readWord[DMA_EP_LSB +: DMA_EP_W]       = state.dmaEp;
				readWord[DMA_EN_BIT]                   = state.dmaEn;
				readWord[DMA_BURST_LSB +: DMA_BURST_W] = state.dmaBurst;
			end
			REG_ALLOC: begin
				readWord[ALLOC_W-1:0]     = state.allocSize;
				readWord[ALLOC_DOUBLE_BIT] = state.allocDouble;
			end
			REG_STATUS: begin
				readWord = statusWord;
			end
			default: begin
				readWord = '0;
			end
		endcase
	end

	// Requested DMA fields; the burst is capped, the endpoint is taken as written
	assign wrEp    = regWrData[DMA_EP_LSB +: DMA_EP_W];
	assign wrBurst = (regWrData[DMA_BURST_LSB +: DMA_BURST_W] > DMA_MAX_BURST)
	               ? DMA_MAX_BURST : regWrData[DMA_BURST_LSB +: DMA_BURST_W];

	// Next-state logic
	always_comb begin
		next_state = state;

		// Port mode and DMA width straps caught once after reset release
		if (!state.strapDone) begin
			next_state.mode      = ucl_mode_type'({portModeSelectHi, portModeSelectLo});
			next_state.dmaWide   = dmaWidthSelect;
			next_state.strapDone = 1'b1;
		end

		// Register writes
		if (regWrite) begin
			case (regAddr)
				REG_CTRL: begin
					next_state.connectCmd = regWrData[CTRL_CONNECT];
					next_state.clkOutEn   = regWrData[CTRL_PROGRAMMABLE_CLOCK_OUT_EN];
					next_state.slowEn     = regWrData[CTRL_SLOW_EN];
				end
				REG_CLKDIV: begin
					next_state.clkDiv = regWrData[DIV_W-1:0];
				end
				REG_DMACFG: begin
					next_state.dmaEp    = wrEp;
					next_state.dmaBurst = wrBurst;
					// Only endpoints 1 to 14 may be bound to the DMA port
					next_state.dmaEn    = regWrData[DMA_EN_BIT]
					                   && (wrEp >= EP_FIRST) && (wrEp <= EP_LAST);
				end
				REG_ALLOC: begin
					next_state.allocSize   = regWrData[ALLOC_W-1:0];
					next_state.allocDouble = regWrData[ALLOC_DOUBLE_BIT];
				end
				default: begin
				end
			endcase
		end

		// Register read data, narrowed to a byte on the 8-bit port
		if (regRead) begin
			next_state.rdData = (state.mode == MODE_8) ? (readWord & BYTE_MASK) : readWord;
		end else begin
			next_state.rdData = '0;
		end

		// Address latch: falling ALE takes the lowest data line as command/data
		next_state.aleQ = ale;
		if (state.aleQ && !ale) begin
			next_state.cmdSel = muxedAddrDataBit0;
		end

		// Pull-up connection control
		case (state.conn)
			CONN_DETACHED: begin
				if (state.connectCmd) begin
					next_state.conn = vbusSense ? CONN_ATTACHED : CONN_WAIT;
				end
			end
			CONN_WAIT: begin
				if (!state.connectCmd) begin
					next_state.conn = CONN_DETACHED;
				end else if (vbusSense) begin
					next_state.conn = CONN_ATTACHED;
				end
			end
			CONN_ATTACHED: begin
				if (!state.connectCmd) begin
					next_state.conn = CONN_DETACHED;
				end else if (!vbusSense) begin
					next_state.conn = CONN_WAIT;
				end
			end
			default: begin
				next_state.conn = CONN_DETACHED;
			end
		endcase

		next_state.suspend = suspendNow;

		// Link-status indicator sequencing
		case (state.led)
			LED_IDLE: begin
				if (addrAssigned) begin
					next_state.led = LED_ON;
				end else if (enumEvent) begin
					next_state.led    = LED_BLINK;
					next_state.ledCnt = BLINK_LOAD;
				end
			end
			LED_BLINK: begin
				if (addrAssigned) begin
					next_state.led = LED_ON;
				end else if (state.ledCnt == '0) begin
					next_state.led = LED_IDLE;
				end else begin
					next_state.ledCnt = state.ledCnt - LED_CNT_W'(1);
				end
			end
			LED_ON: begin
				if (!addrAssigned) begin
					next_state.led = LED_IDLE;
				end else if (ackDone) begin
					next_state.led    = LED_DARK;
					next_state.ledCnt = DARK_LOAD;
				end
			end
			LED_DARK: begin
				if (!addrAssigned) begin
					next_state.led = LED_IDLE;
				end else if (ackDone) begin
					next_state.ledCnt = DARK_LOAD;
				end else if (state.ledCnt == '0) begin
					next_state.led = LED_ON;
				end else begin
					next_state.ledCnt = state.ledCnt - LED_CNT_W'(1);
				end
			end
			default: begin
				next_state.led = LED_IDLE;
			end
		endcase

		// Lit only in blink or steady state, and never while suspended
		next_state.ledLit = ((next_state.led == LED_BLINK) || (next_state.led == LED_ON))
		                 && !suspendNow;
	end

	// State register; reset needs no clock
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state      <= '0;
			state.conn <= CONN_DETACHED;
			state.led  <= LED_IDLE;
			state.mode <= MODE_16;
		end else begin
			state <= next_state;
		end
	end

	// Clock output: programmed divider, slow clock while suspended
	assign halfPeriod = (state.suspend && state.slowEn) ? SLOW_HALF : state.clkDiv;
	assign clkOutRun  = state.clkOutEn && (!state.suspend || state.slowEn);

	ucl_clk_div #(
		.CNT_W      (DIV_W)
	) clkDivInst (
		.clock      (clock),
		.rst        (rst),
		.enable     (clkOutRun),
		.halfPeriod (halfPeriod),
		.clockOut   (programmableClockOut)
	);

	// Receive bit recovery, decoupled from the lines without bus power
	ucl_bit_recovery bitRecInst (
		.clock      (clock),
		.rst        (rst),
		.enable     (vbusSense),
		.sampleTick (rxSampleTick),
		.rxLine     (rxLine),
		.bitValid   (rxBitValid),
		.bitData    (rxBitData),
		.stuffError (rxStuffError)
	);

	// Outputs from flip-flops
	assign regRdData      = state.rdData;
	assign pullUpAttach   = state.conn == CONN_ATTACHED;
	assign suspendActive  = state.suspend;
	assign cmdSelect      = state.cmdSel;
	assign linkStatusLedN = !state.ledLit;
	assign dmaEnabled     = state.dmaEn && dmaWidthOk && !modeReserved;
	assign dmaEndpoint    = state.dmaEp;
	assign dmaBurstBytes  = state.dmaBurst;

endmodule
`default_nettype wire

// ---- rtl/ucl_pkg.sv ----
package ucl_pkg;

	// Clock rates
	localparam int CLK_HZ      = 25_000_000;
	localparam int REF_HZ      = 6_000_000;
	localparam int PLL_MULT    = 8;
	localparam int CORE_HZ     = REF_HZ * PLL_MULT;
	localparam int SLOW_CLK_HZ = 100_000;

	// Link-status indicator timing
	localparam int LED_DARK_MS      = 100;
	localparam int LED_BLINK_MS     = 50;
	localparam int LED_DARK_CYCLES  = (CLK_HZ / 1000) * LED_DARK_MS;
	localparam int LED_BLINK_CYCLES = (CLK_HZ / 1000) * LED_BLINK_MS;
	localparam int LED_CNT_W        = 22;

	// Clock output divider
	localparam int DIV_W = 8;
	localparam logic [DIV_W-1:0] SLOW_HALF = DIV_W'(CLK_HZ / (2 * SLOW_CLK_HZ));

	// Register port
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
	localparam logic [ADDR_W-1:0] REG_CLKDIV = 4'h1;
	localparam logic [ADDR_W-1:0] REG_DMACFG = 4'h2;
	localparam logic [ADDR_W-1:0] REG_ALLOC  = 4'h3;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
	localparam logic [DATA_W-1:0] BYTE_MASK  = 16'h00ff;

	// Control register fields
	localparam int CTRL_CONNECT   = 0;
	localparam int CTRL_PROGRAMMABLE_CLOCK_OUT_EN = 1;
	localparam int CTRL_SLOW_EN   = 2;

	// DMA configuration fields
	localparam int DMA_EP_LSB    = 0;
	localparam int DMA_EP_W      = 4;
	localparam int DMA_EN_BIT    = 4;
	localparam int DMA_BURST_LSB = 8;
	localparam int DMA_BURST_W   = 5;
	localparam logic [DMA_EP_W-1:0]    EP_FIRST      = 4'h1;
	localparam logic [DMA_EP_W-1:0]    EP_LAST       = 4'he;
	localparam logic [DMA_BURST_W-1:0] DMA_MAX_BURST = 5'h10;

	// Packet buffer allocation fields
	localparam int ALLOC_W          = 12;
	localparam int ALLOC_DOUBLE_BIT = 12;
	localparam logic [ALLOC_W:0] BUF_BYTES = 13'h099e;

	// Status register fields
	localparam int ST_VBUS     = 0;
	localparam int ST_PULLUP   = 1;
	localparam int ST_SUSPEND  = 2;
	localparam int ST_ADDRESS  = 3;
	localparam int ST_LED      = 4;
	localparam int ST_CMDSEL   = 5;
	localparam int ST_MODE_LSB = 6;
	localparam int ST_MODE_RSV = 8;
	localparam int ST_DMA_OK   = 9;
	localparam int ST_ALLOC_OV = 10;
	localparam int ST_WAIT     = 11;

	// Clock recovery
	localparam logic [1:0] PHASE_MID = 2'h2;
	localparam logic [2:0] MAX_ONES  = 3'h6;

	typedef enum logic [1:0] {
		MODE_16   = 2'h0,
		MODE_RSV1 = 2'h1,
		MODE_8    = 2'h2,
		MODE_RSV3 = 2'h3
	} ucl_mode_type;

	typedef enum logic [1:0] {
		CONN_DETACHED = 2'b00,
		CONN_WAIT     = 2'b01,
		CONN_ATTACHED = 2'b11
	} ucl_conn_type;

	typedef enum logic [1:0] {
		LED_IDLE  = 2'b00,
		LED_BLINK = 2'b01,
		LED_ON    = 2'b11,
		LED_DARK  = 2'b10
	} ucl_led_type;

endpackage

// ---- rtl/ucl_clk_div.sv ----
`timescale 1ns/1ps
`default_nettype none
module ucl_clk_div
	import ucl_pkg::*;
#(
	parameter int CNT_W = DIV_W
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic             enable,
	input  wire logic [CNT_W-1:0] halfPeriod,
	output logic                  clockOut
);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             out;
	} ucl_div_type;

	ucl_div_type state;
	ucl_div_type next_state;

	// Toggle every halfPeriod cycles, zero counts as one
	always_comb begin
		next_state = state;
		if (!enable) begin
			next_state.cnt = '0;
			next_state.out = 1'b0;
		end else if (state.cnt + CNT_W'(1) >= halfPeriod) begin
			next_state.cnt = '0;
			next_state.out = !state.out;
		end else begin
			next_state.cnt = state.cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign clockOut = state.out;

endmodule
`default_nettype wire

// ---- rtl/ucl_bit_recovery.sv ----
`timescale 1ns/1ps
`default_nettype none
module ucl_bit_recovery
	import ucl_pkg::*;
(
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic enable,
	input  wire logic sampleTick,
	input  wire logic rxLine,
	output logic      bitValid,
	output logic      bitData,
	output logic      stuffError
);

	typedef struct packed {
		logic [1:0] phase;
		logic       lastSample;
		logic       lastBitLine;
		logic [2:0] ones;
		logic       valid;
		logic       data;
		logic       stuffErr;
	} ucl_rec_type;

	ucl_rec_type state;
	ucl_rec_type next_state;
	logic        decoded;

	// Four samples per bit; a line transition realigns the phase
	always_comb begin
		next_state          = state;
		next_state.valid    = 1'b0;
		next_state.stuffErr = 1'b0;
		decoded             = (rxLine == state.lastBitLine);
		if (!enable) begin
			next_state.phase = '0;
			next_state.ones  = '0;
		end else if (sampleTick) begin
			next_state.lastSample = rxLine;
			if (rxLine != state.lastSample) begin
				next_state.phase = 2'h1;
			end else begin
				next_state.phase = state.phase + 2'h1;
			end
			if (state.phase == PHASE_MID) begin
				next_state.lastBitLine = rxLine;
				if (state.ones == MAX_ONES) begin
					// Stuffed bit dropped; a one here is a stuffing error
					next_state.ones     = '0;
					next_state.stuffErr = decoded;
				end else begin
					next_state.valid = 1'b1;
					next_state.data  = decoded;
					next_state.ones  = decoded ? state.ones + 3'h1 : 3'h0;
				end
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign bitValid   = state.valid;
	assign bitData    = state.data;
	assign stuffError = state.stuffErr;

endmodule
`default_nettype wire

// ---- verif/ucl_link_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module ucl_link_checker
	import ucl_pkg::*;
(
	input wire logic                   clock,
	input wire logic                   rst,
	input wire logic                   vbusSense,
	input wire logic                   sieSuspend,
	input wire logic                   ale,
	input wire logic                   muxedAddrDataBit0,
	input wire logic                   regRead,
	input wire logic                   ackDone,
	input wire logic                   addrAssigned,
	input wire logic [DATA_W-1:0]      regRdData,
	input wire logic                   pullUpAttach,
	input wire logic                   suspendActive,
	input wire logic                   cmdSelect,
	input wire logic                   linkStatusLedN,
	input wire logic                   rxBitValid,
	input wire logic                   rxStuffError,
	input wire logic                   dmaEnabled,
	input wire logic [DMA_EP_W-1:0]    dmaEndpoint,
	input wire logic [DMA_BURST_W-1:0] dmaBurstBytes
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// Reset state, then pull-up, suspend and receiver gated by bus power
	AST_RESET_DETACHED: assert property ($fell(rst) |-> !pullUpAttach && linkStatusLedN)
		else $error("not detached after reset");
	AST_PULLUP_VBUS: assert property ((!vbusSense) [*3] |-> !pullUpAttach)
		else $error("pull-up without bus power");
	AST_ATTACH_VBUS: assert property ($rose(pullUpAttach) |-> $past(vbusSense))
		else $error("attach without bus power");
	AST_SUSPEND_NOVBUS: assert property ((sieSuspend || !vbusSense) |=> suspendActive)
		else $error("suspend not shown");
	AST_RX_QUIET: assert property ((!vbusSense) [*3] |-> !rxBitValid && !rxStuffError)
		else $error("receive activity without bus power");
	// Indicator behaviour
	AST_SUSPEND_DARK: assert property (sieSuspend [*3] |-> linkStatusLedN)
		else $error("indicator lit in suspend");
	AST_ACK_DARK: assert property (ackDone && addrAssigned && !linkStatusLedN
		|-> ##2 linkStatusLedN [*8])
		else $error("indicator not dark after acknowledge");
	// Parallel port and DMA
	AST_ALE_LATCH: assert property ($fell(ale) |-> ##2 cmdSelect == $past(muxedAddrDataBit0, 2))
		else $error("select bit not latched");
	AST_READ_IDLE: assert property (!$past(regRead) |-> regRdData == 16'h0000)
		else $error("read data outside its cycle");
	AST_DMA_EP: assert property (dmaEnabled |-> dmaEndpoint >= EP_FIRST && dmaEndpoint <= EP_LAST)
		else $error("DMA endpoint out of range");
	AST_DMA_BURST: assert property (dmaBurstBytes <= DMA_MAX_BURST)
		else $error("DMA burst too long");
endmodule
bind ucl_link ucl_link_checker checker_i (.clock(clock), .rst(rst), .vbusSense(vbusSense),
	.sieSuspend(sieSuspend), .ale(ale), .muxedAddrDataBit0(muxedAddrDataBit0),
	.regRead(regRead), .ackDone(ackDone), .addrAssigned(addrAssigned), .regRdData(regRdData),
	.pullUpAttach(pullUpAttach), .suspendActive(suspendActive), .cmdSelect(cmdSelect),
	.linkStatusLedN(linkStatusLedN), .rxBitValid(rxBitValid), .rxStuffError(rxStuffError),
	.dmaEnabled(dmaEnabled), .dmaEndpoint(dmaEndpoint), .dmaBurstBytes(dmaBurstBytes));
`default_nettype wire

// ---- verif/ucl_far_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ucl_far_model (
	input  wire logic clock,
	input  wire logic rst,
	output logic      rxLine,
	output logic      rxSampleTick,
	output logic      ale,
	output logic      muxedAddrDataBit0
);
	// Idle line high, bus strobes low
	initial begin
		rxLine = 1'b1;
		ale = 1'b0;
		muxedAddrDataBit0 = 1'b0;
	end
	// Sample tick at half the clock rate
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			rxSampleTick <= 1'b0;
		end else begin
			rxSampleTick <= !rxSampleTick;
		end
	end
	// One bit spans four ticks; a zero is a change of level
	task automatic sendBit(input logic b);
		@(posedge clock);
		if (b === 1'b0) begin
			rxLine <= !rxLine;
		end
		repeat (7) @(posedge clock);
	endtask
	// Address phase, then the shared line is driven to the opposite level
	task automatic latchSelect(input logic b);
		@(posedge clock);
		ale <= 1'b1;
		muxedAddrDataBit0 <= b;
		@(posedge clock);
		ale <= 1'b0;
		@(posedge clock);
		muxedAddrDataBit0 <= !b;
		repeat (2) @(posedge clock);
	endtask
endmodule
`default_nettype wire

// ---- verif/test_ucl_link.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_ucl_link
	import ucl_pkg::*;
;
	logic                   clock, rst;
	logic [ADDR_W-1:0]      regAddr;
	logic [DATA_W-1:0]      regWrData, regRdData, s;
	logic                   regWrite, regRead, vbusSense;
	logic                   portModeSelectHi, portModeSelectLo;
	logic                   dmaWidthSelect, sieSuspend, enumEvent;
	logic                   addrAssigned, ackDone, lastBit = 1'b0;
	logic                   pullUpAttach, suspendActive, cmdSelect, linkStatusLedN;
	logic                   programmableClockOut, rxBitValid, rxBitData, rxStuffError;
	logic                   rxLine, rxSampleTick, ale, muxedAddrDataBit0, dmaEnabled;
	logic [DMA_EP_W-1:0]    dmaEndpoint;
	logic [DMA_BURST_W-1:0] dmaBurstBytes;
	int                     fails = 0, cmpCount = 0, cycleCount = 0, nValid = 0, nStuff = 0;

	ucl_link #(.DARK_CYCLES(20), .BLINK_CYCLES(10)) dut (.clock(clock), .rst(rst),
		.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .vbusSense(vbusSense), .portModeSelectHi(portModeSelectHi),
		.portModeSelectLo(portModeSelectLo), .dmaWidthSelect(dmaWidthSelect), .ale(ale),
		.muxedAddrDataBit0(muxedAddrDataBit0), .rxLine(rxLine), .rxSampleTick(rxSampleTick),
		.sieSuspend(sieSuspend), .enumEvent(enumEvent), .addrAssigned(addrAssigned),
		.ackDone(ackDone), .pullUpAttach(pullUpAttach), .suspendActive(suspendActive),
		.cmdSelect(cmdSelect), .linkStatusLedN(linkStatusLedN),
		.programmableClockOut(programmableClockOut), .rxBitValid(rxBitValid),
		.rxBitData(rxBitData), .rxStuffError(rxStuffError), .dmaEnabled(dmaEnabled),
		.dmaEndpoint(dmaEndpoint), .dmaBurstBytes(dmaBurstBytes));
	ucl_far_model far (.clock(clock), .rst(rst), .rxLine(rxLine), .rxSampleTick(rxSampleTick),
		.ale(ale), .muxedAddrDataBit0(muxedAddrDataBit0));

	always #20 clock = ~clock;
	// Hang guard and receive monitor
	always @(posedge clock) begin
		cycleCount++;
		if (rxBitValid === 1'b1) begin
			lastBit <= rxBitData;
			nValid <= nValid + 1;
		end
		if (rxStuffError === 1'b1) begin
			nStuff <= nStuff + 1;
		end
		if (cycleCount == 20000) begin
			fails++;
			summarize();
		end
	end
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmpCount, fails);
		if (fails == 0 && cmpCount > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] v);
		cmpCount++;
		if (v !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, v);
		end
	endtask
	// Register port: one-cycle strobes, read data in the following cycle
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clock);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		@(negedge clock);
		s = regRdData;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clock);
		@(negedge clock);
	endtask
	task automatic toggleGap(output int n);
		logic t;
		n = 0;
		t = programmableClockOut;
		while (programmableClockOut === t && n < 400) begin
			@(negedge clock);
			n++;
		end
	endtask

	initial begin
		int n;
		clock = 1'b0;
		rst <= 1'b1;
		{regAddr, regWrData, regWrite, regRead, vbusSense} <= '0;
		{portModeSelectHi, portModeSelectLo, sieSuspend, enumEvent} <= '0;
		{addrAssigned, ackDone} <= '0;
		dmaWidthSelect <= 1'b1;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		settle(2);
		chk("pullUpAttach", 16'h0, pullUpAttach);
		chk("suspendActive", 16'h1, suspendActive);
		wr(REG_CTRL, 16'h0001);
		settle(3);
		chk("pullUpAttach", 16'h0, pullUpAttach);
		@(posedge clock);
		vbusSense <= 1'b1;
		settle(3);
		chk("pullUpAttach", 16'h1, pullUpAttach);
		rd(REG_STATUS);
		chk("status", 16'h0003, s & 16'h0003);
		rd(4'hf);
		chk("unmapped", 16'h0, s);
		wr(REG_CTRL, 16'h0000);
		settle(3);
		chk("pullUpAttach", 16'h0, pullUpAttach);
		wr(REG_CTRL, 16'h0001);
		settle(3);
		chk("pullUpAttach", 16'h1, pullUpAttach);
		// Receive path: a first zero aligns the phase, a level change is a zero
		repeat (2) far.sendBit(1'b0);
		settle(0);
		chk("rxBit", 16'h0, lastBit);
		far.sendBit(1'b1);
		settle(0);
		chk("rxBit", 16'h1, lastBit);
		far.sendBit(1'b0);
		n = nStuff;
		repeat (7) far.sendBit(1'b1);
		settle(0);
		chk("stuffErrors", 16'h1, 16'(nStuff - n));
		@(posedge clock);
		vbusSense <= 1'b0;
		settle(3);
		chk("pullUpAttach", 16'h0, pullUpAttach);
		n = nValid;
		repeat (3) far.sendBit(1'b0);
		settle(0);
		chk("rxBitsNoPower", 16'h0, 16'(nValid - n));
		@(posedge clock);
		vbusSense <= 1'b1;
		// Indicator: blink, lit, dark after acknowledge with restart, suspend
		@(posedge clock);
		enumEvent <= 1'b1;
		@(posedge clock);
		enumEvent <= 1'b0;
		settle(3);
		chk("ledN", 16'h0, linkStatusLedN);
		settle(15);
		chk("ledN", 16'h1, linkStatusLedN);
		@(posedge clock);
		addrAssigned <= 1'b1;
		settle(3);
		chk("ledN", 16'h0, linkStatusLedN);
		for (int i = 0; i < 2; i++) begin
			@(posedge clock);
			ackDone <= 1'b1;
			@(posedge clock);
			ackDone <= 1'b0;
			settle(3);
			chk("ledN", 16'h1, linkStatusLedN);
			repeat (5) @(posedge clock);
		end
		settle(8);
		chk("ledN", 16'h1, linkStatusLedN);
		settle(8);
		chk("ledN", 16'h0, linkStatusLedN);
		// Clock output: slow clock in suspend, divided clock otherwise
		wr(REG_CLKDIV, 16'h0003);
		wr(REG_CTRL, 16'h0007);
		@(posedge clock);
		sieSuspend <= 1'b1;
		settle(3);
		chk("ledN", 16'h1, linkStatusLedN);
		toggleGap(n);
		toggleGap(n);
		chk("slowHalf", 16'd125, 16'(n));
		@(posedge clock);
		sieSuspend <= 1'b0;
		settle(3);
		toggleGap(n);
		toggleGap(n);
		chk("clkHalf", 16'd3, 16'(n));
		// Command/data select on the falling address strobe
		far.latchSelect(1'b1);
		settle(0);
		chk("cmdSelect", 16'h1, cmdSelect);
		far.latchSelect(1'b0);
		settle(0);
		chk("cmdSelect", 16'h0, cmdSelect);
		// DMA: out-of-range endpoint refused, burst capped
		wr(REG_DMACFG, 16'h1f1f);
		settle(2);
		chk("dmaEnabled", 16'h0, dmaEnabled);
		wr(REG_DMACFG, 16'h1f1e);
		settle(2);
		chk("dmaEnabled", 16'h1, dmaEnabled);
		chk("dmaEndpoint", 16'h000e, dmaEndpoint);
		chk("dmaBurst", 16'h0010, dmaBurstBytes);
		// Shared buffer: a doubled 1231 fits exactly, 1232 overflows
		wr(REG_ALLOC, 16'h14cf);
		rd(REG_STATUS);
		chk("allocOver", 16'h0000, s & 16'h0400);
		wr(REG_ALLOC, 16'h14d0);
		rd(REG_STATUS);
		chk("allocOver", 16'h0400, s & 16'h0400);
		// Asynchronous reset mid-run, then the 8-bit mode
		@(posedge clock);
		#7 rst = 1'b1;
		#1;
		chk("pullUpAttach", 16'h0, pullUpAttach);
		chk("ledN", 16'h1, linkStatusLedN);
		@(posedge clock);
		portModeSelectHi <= 1'b1;
		dmaWidthSelect <= 1'b0;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
		rd(REG_STATUS);
		chk("mode", 16'h0080, s & 16'h00c0);
		wr(REG_DMACFG, 16'h0111);
		settle(2);
		chk("dmaEnabled", 16'h1, dmaEnabled);
		// Reserved mode 3: flagged in status, DMA port kept off
		@(posedge clock);
		rst <= 1'b1;
		portModeSelectLo <= 1'b1;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
		rd(REG_STATUS);
		chk("modeReserved", 16'h01c0, s & 16'h01c0);
		wr(REG_DMACFG, 16'h0111);
		settle(2);
		chk("dmaEnabled", 16'h0, dmaEnabled);
		summarize();
	end
endmodule
`default_nettype wire
